// [rtl/dtr_pkg.sv]
// Package of constants and types for the tone receiver decode block
package dtr_pkg;
   // Register byte addresses
   localparam logic [11:0] CTRL_ADDR   = 12'h000;
   localparam logic [11:0] CODE_ADDR   = 12'h004;
   localparam logic [11:0] STAT_ADDR   = 12'h008;
   localparam logic [11:0] MASK_ADDR   = 12'h00c;
   // Control field positions
   localparam int          PWDN_BIT    = 0;
   localparam int          INH_BIT     = 1;
   localparam int          DV_BIT      = 2;
   localparam logic        PWDN_RST    = 1'b1;
   localparam logic        INH_RST     = 1'b0;
   // Interrupt status bits
   localparam int          EV_TONE     = 0;
   localparam int          EV_END      = 1;
   localparam int          EV_W        = 2;
   // Tone codes
   localparam logic [3:0]  CODE_ZERO   = 4'ha;
   localparam logic [3:0]  CODE_STAR   = 4'hb;
   localparam logic [3:0]  CODE_HASH   = 4'hc;
   localparam logic [3:0]  CODE_A      = 4'hd;
   localparam logic [3:0]  CODE_B      = 4'he;
   localparam logic [3:0]  CODE_C      = 4'hf;
   localparam logic [3:0]  CODE_D      = 4'h0;

   // One-hot tone group inputs
   typedef struct packed {
      logic [3:0] low_grp;
      logic [3:0] high_grp;
   } dtr_tone_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_EARLY  = 2'b01,
      ST_VALID  = 2'b11
   } dtr_state_t;
endpackage

// [rtl/dtr_receiver.sv]
// Digital decode, steering and register logic of the dual-tone receiver
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Control bit 0 powers receiver down; resets to one.
// - Control bit 1 set ignores letter tones A to D; resets to zero.
// - Control bit 2 reads one after a valid tone was received.
// - Control bits 7 to 3 read as zero.
// - Hardware sets valid flag; only software writing zero clears it.
// - Valid tone yields its code and raises an interrupt request.
// - Code: digits binary, 0=1010, star 1011, hash 1100, A-D 1101..0000.
// - Steering node rising above threshold latches code, then raises data valid.
// - Steering node falling drops data valid; code output holds.
// - Early steering output rests low, goes high on a detected tone.
module dtr_receiver
   import dtr_pkg::*;
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Tone detector and steering node
   input  wire dtr_tone_t   i_tone,
   input  wire logic        i_steering_threshold,
   output logic             o_early_steering_out,
   output logic [3:0]       o_tone_code_out,
   output logic             o_code_valid_out,
   // Interrupt
   output logic             o_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic             receiver_power_down;
   logic             letter_tone_inhibit;
   logic             tone_valid_flag;
   logic [EV_W-1:0]  irq_stat;
   logic [EV_W-1:0]  irq_mask;
   logic [3:0]       code_q;
   logic             code_ok;
   logic             thr_q;
   dtr_state_t       state;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             irq;

   // Next values
   logic             next_receiver_power_down;
   logic             next_letter_tone_inhibit;
   logic             next_tone_valid_flag;
   logic [EV_W-1:0]  next_irq_stat;
   logic [EV_W-1:0]  next_irq_mask;
   logic [3:0]       next_code_q;
   logic             next_thr_q;
   dtr_state_t       next_state;
   logic [31:0]      next_prdata;
   logic             next_pready;
   logic             next_pslverr;
   logic             next_irq;
   logic             next_est;
   logic             next_dv;

   // Decoder and bus strobes
   logic [3:0]       dec_code;
   logic             dec_valid;
   logic             dec_letter;
   logic             acc;
   logic             wait_ph;
   logic             wr_acc;
   logic             rd_acc;
   logic             addr_ok;
   logic             ev_tone;
   logic             ev_end;

   ////////////////////////////////////////////////////////////////////////////
   // Tone decoder
   always_comb begin
      dec_code   = CODE_D;
      dec_valid  = 1'b1;
      dec_letter = 1'b0;
      case ({i_tone.low_grp, i_tone.high_grp})
         8'h11:   dec_code = 4'h1;
         8'h12:   dec_code = 4'h2;
         8'h14:   dec_code = 4'h3;
         8'h21:   dec_code = 4'h4;
         8'h22:   dec_code = 4'h5;
         8'h24:   dec_code = 4'h6;
         8'h41:   dec_code = 4'h7;
         8'h42:   dec_code = 4'h8;
         8'h44:   dec_code = 4'h9;
         8'h82:   dec_code = CODE_ZERO;
         8'h81:   dec_code = CODE_STAR;
         8'h84:   dec_code = CODE_HASH;
         8'h18: begin
            dec_code   = CODE_A;
            dec_letter = 1'b1;
         end
         8'h28: begin
            dec_code   = CODE_B;
            dec_letter = 1'b1;
         end
         8'h48: begin
            dec_code   = CODE_C;
            dec_letter = 1'b1;
         end
         8'h88: begin
            dec_code   = CODE_D;
            dec_letter = 1'b1;
         end
         // Single tones and chords decode as invalid
         default: dec_valid = 1'b0;
      endcase
   end

   // Pair accepted unless inhibited letter or powered down
   assign code_ok = dec_valid && !(dec_letter && letter_tone_inhibit)
                    && !receiver_power_down;

   ////////////////////////////////////////////////////////////////////////////
   // Steering sequence
   always_comb begin
      next_state  = state;
      next_code_q = code_q;
      next_thr_q  = i_steering_threshold;
      next_est    = 1'b0;
      next_dv     = 1'b0;
      ev_tone     = 1'b0;
      ev_end      = 1'b0;
      case (state)
         ST_IDLE: begin
            if (code_ok) begin
               next_state = ST_EARLY;
               next_est   = 1'b1;
            end
         end
         ST_EARLY: begin
            // A node already above threshold is no edge: it must discharge
            // before another tone can be latched
            next_est = code_ok;
            if (!code_ok && !i_steering_threshold) begin
               next_state = ST_IDLE;
            end else if (i_steering_threshold && !thr_q && code_ok) begin
               // Code latched first, data valid one cycle later
               next_code_q = dec_code;
               next_state  = ST_VALID;
               ev_tone     = 1'b1;
            end
         end
         ST_VALID: begin
            next_est = code_ok;
            next_dv  = 1'b1;
            // Power-down ends the tone at once and posts no end event
            if (!i_steering_threshold || receiver_power_down) begin
               next_dv    = 1'b0;
               next_state = ST_IDLE;
               ev_end     = !receiver_power_down;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   // One wait state: read data and error are prepared while pready is still
   // low, so they already stand at the edge where pready is sampled high.
   assign acc     = i_psel && i_penable && pready;
   assign wait_ph = i_psel && i_penable && !pready;
   assign addr_ok = (i_paddr == CTRL_ADDR) || (i_paddr == CODE_ADDR)
                    || (i_paddr == STAT_ADDR) || (i_paddr == MASK_ADDR);
   assign wr_acc  = acc && i_pwrite && addr_ok && i_pstrb[0];
   assign rd_acc  = wait_ph && !i_pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // Control, status and mask next values
   always_comb begin
      next_receiver_power_down = receiver_power_down;
      next_letter_tone_inhibit = letter_tone_inhibit;
      next_tone_valid_flag     = tone_valid_flag;
      next_irq_stat            = irq_stat;
      next_irq_mask            = irq_mask;
      if (wr_acc && i_paddr == CTRL_ADDR) begin
         next_receiver_power_down = i_pwdata[PWDN_BIT];
         next_letter_tone_inhibit = i_pwdata[INH_BIT];
         next_tone_valid_flag     = i_pwdata[DV_BIT];
      end
      if (wr_acc && i_paddr == STAT_ADDR) begin
         next_irq_stat = irq_stat & ~i_pwdata[EV_W-1:0];
      end
      if (wr_acc && i_paddr == MASK_ADDR) begin
         next_irq_mask = i_pwdata[EV_W-1:0];
      end
      // Hardware set wins over a simultaneous clear
      if (ev_tone) begin
         next_tone_valid_flag   = 1'b1;
         next_irq_stat[EV_TONE] = 1'b1;
      end
      if (ev_end) begin
         next_irq_stat[EV_END] = 1'b1;
      end
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer next values
   // A flag that hardware sets on the taken edge shows at the next read.
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      next_pready  = wait_ph;
      if (rd_acc) begin
         case (i_paddr)
            CTRL_ADDR: next_prdata = {29'h0, tone_valid_flag, letter_tone_inhibit,
                                      receiver_power_down};
            CODE_ADDR: next_prdata = {27'h0, o_code_valid_out, code_q};
            STAT_ADDR: next_prdata = {30'h0, irq_stat};
            MASK_ADDR: next_prdata = {30'h0, irq_mask};
            default:   next_pslverr = 1'b1;
         endcase
      end
      // Unmapped writes are refused with an error and change nothing
      if (wait_ph && i_pwrite && !addr_ok) begin
         next_pslverr = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Steering registers
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state                <= ST_IDLE;
         code_q               <= CODE_D;
         thr_q                <= 1'b0;
         o_early_steering_out <= 1'b0;
         o_code_valid_out     <= 1'b0;
         o_tone_code_out      <= CODE_D;
      end else begin
         // Code output moves with the latch, a cycle before data valid
         state                <= next_state;
         code_q               <= next_code_q;
         thr_q                <= next_thr_q;
         o_early_steering_out <= next_est;
         o_code_valid_out     <= next_dv;
         o_tone_code_out      <= next_code_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and interrupt registers
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         receiver_power_down  <= PWDN_RST;
         letter_tone_inhibit  <= INH_RST;
         tone_valid_flag      <= 1'b0;
         irq_stat             <= '0;
         irq_mask             <= '0;
         irq                  <= 1'b0;
      end else begin
         receiver_power_down  <= next_receiver_power_down;
         letter_tone_inhibit  <= next_letter_tone_inhibit;
         tone_valid_flag      <= next_tone_valid_flag;
         irq_stat             <= next_irq_stat;
         irq_mask             <= next_irq_mask;
         irq                  <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer registers
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prdata               <= 32'h0000_0000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
      end else begin
         // Answer stands for one cycle only
         prdata               <= next_prdata;
         pready               <= next_pready;
         pslverr              <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_prdata  = prdata;
   assign o_pready  = pready;
   assign o_pslverr = pslverr;
   assign o_irq     = irq;

endmodule // dtr_receiver

// [dv/dtr_receiver_properties.sv]
// Port checker for the tone receiver decode block
`timescale 1ns/1ps
module dtr_receiver_properties
   import dtr_pkg::*;
(
   input wire logic        i_ref_clk, i_resetn, i_psel, i_penable, i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0]  i_pstrb,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready, o_pslverr,
   input wire dtr_tone_t   i_tone,
   input wire logic        i_steering_threshold, o_early_steering_out,
   input wire logic [3:0]  o_tone_code_out,
   input wire logic        o_code_valid_out, o_irq
);
   wire tone_on = |i_tone.low_grp && |i_tone.high_grp;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_setup; i_psel && !i_penable ##1 i_psel && i_penable; endsequence
   sequence s_quiet; !tone_on [*3]; endsequence
   property p_wait; s_setup |=> o_pready; endproperty
   property p_pulse; o_pready |=> !o_pready; endproperty
   property p_err; o_pslverr |-> o_pready; endproperty
   property p_rsvd; o_pready && !i_pwrite && i_paddr == CTRL_ADDR |-> o_prdata[31:3] == '0;
   endproperty
   property p_latch; $rose(o_code_valid_out) |-> $past(o_early_steering_out)
      && $stable(o_tone_code_out); endproperty
   property p_drop; o_code_valid_out && !i_steering_threshold |=> !o_code_valid_out;
   endproperty
   property p_hold; $changed(o_tone_code_out) |-> o_early_steering_out && !o_code_valid_out;
   endproperty
   property p_est; $rose(o_early_steering_out) |-> $past(tone_on); endproperty
   property p_rest; s_quiet |-> !o_early_steering_out; endproperty
   a_wait: assert property (p_wait) else $error("late pready");
   a_pulse: assert property (p_pulse) else $error("long pready");
   a_err: assert property (p_err) else $error("stray pslverr");
   a_rsvd: assert property (p_rsvd) else $error("unused bits set");
   a_latch: assert property (p_latch) else $error("dv before code");
   a_drop: assert property (p_drop) else $error("dv held");
   a_hold: assert property (p_hold) else $error("code moved");
   a_est: assert property (p_est) else $error("est without tone");
   a_rest: assert property (p_rest) else $error("est not resting");
endmodule // dtr_receiver_properties
bind dtr_receiver dtr_receiver_properties u_props (.*);

// [dv/dtr_tone_src.sv]
// Behavioural tone source and steering RC network
`timescale 1ns/1ps
module dtr_tone_src
   import dtr_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_on,
   input  wire logic [3:0] i_key,
   input  wire logic [3:0] i_rise,
   input  wire logic       i_est,
   output dtr_tone_t       o_tone,
   output logic            o_thr
);
   logic [4:0] lvl = '0;
   initial o_thr = 1'b0;
   // Node charges while early steering is high, discharges otherwise
   always @(posedge i_ref_clk) begin
      if (i_est && lvl < 5'd16)
         lvl <= lvl + 5'd1;
      else if (!i_est && lvl != 5'd0)
         lvl <= lvl - 5'd1;
      o_thr <= lvl >= {1'b0, i_rise};
   end
   assign o_tone.low_grp  = i_on ? 4'h1 << i_key[3:2] : 4'h0;
   assign o_tone.high_grp = i_on ? 4'h1 << i_key[1:0] : 4'h0;
endmodule // dtr_tone_src

// [dv/dtr_receiver_tb.sv]
// Self-checking bench for the tone receiver decode block
`timescale 1ns/1ps
module dtr_receiver_tb;
   import dtr_pkg::*;
   localparam logic [63:0] TBL = 64'h0cabf987e654d321;
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, on = 0, dv_q = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, early_steering_out, dv, irq, thr;
   logic [3:0]  code, key = '0, rise = 4'h3;
   dtr_tone_t   tone;
   int          n_mismatch = 0, checked = 0, seed = 75450;
   logic [32:0] q[$];
   logic [3:0]  qc[$];
   dtr_receiver dut (.i_ref_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_tone(tone), .i_steering_threshold(thr),
      .o_early_steering_out(early_steering_out), .o_tone_code_out(code), .o_code_valid_out(dv), .o_irq(irq));
   dtr_tone_src u_src (.i_ref_clk(clk), .i_on(on), .i_key(key), .i_rise(rise), .i_est(early_steering_out),
      .o_tone(tone), .o_thr(thr));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wait_for(input int w, input logic v);
      int n;
      n = 0;
      while ((w ? dv : pready) !== v) begin
         if (n++ == 60) begin
            n_mismatch++;
            stop_test();
         end
         @(posedge clk);
      end
   endtask
   task automatic chk_irq(input logic v);
      @(negedge clk);
      chk("irq", {32'h0, v}, {32'h0, irq});
      @(posedge clk);
   endtask
   // Watcher: answers and latched codes against the oldest note
   always @(posedge clk) begin
      if (pready === 1'b1 && psel && pen)
         chk("apb", q.pop_front(), {pslverr, pwr ? 32'h0 : prdata});
      if (dv === 1'b1 && !dv_q)
         chk("code", {29'h0, qc.pop_front()}, {29'h0, code});
      dv_q <= dv;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      q.push_back(e);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      wait_for(0, 1);
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic play(input int k, input logic acc);
      rise <= 4'({$random(seed)} % 8 + 1);
      key <= k[3:0];
      on <= 1;
      if (acc) begin
         qc.push_back(TBL[k*4+:4]);
         wait_for(1, 1);
         chk_irq(1);
      end else begin
         repeat (30) @(posedge clk);
         chk("est", 33'h0, {32'h0, early_steering_out});
      end
      on <= 0;
      wait_for(1, 0);
      // Let the node discharge fully so the next tone sees a fresh rise
      repeat (20) @(posedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      apb(0, CTRL_ADDR, 32'h0, 33'h1);
      apb(0, MASK_ADDR, 32'h0, 33'h0);
      play(5, 0);
      apb(1, CTRL_ADDR, 32'h0, 33'h0);
      apb(1, MASK_ADDR, 32'h1, 33'h0);
      for (int k = 0; k < 16; k++) begin
         play(k, 1);
         apb(0, STAT_ADDR, 32'h0, 33'h3);
         apb(1, STAT_ADDR, 32'h3, 33'h0);
         chk_irq(0);
      end
      apb(0, CTRL_ADDR, 32'h0, 33'h4);
      apb(1, CTRL_ADDR, 32'h2, 33'h0);
      apb(0, CTRL_ADDR, 32'h0, 33'h2);
      play(11, 0);
      play(9, 1);
      apb(0, CODE_ADDR, 32'h0, 33'h8);
      apb(1, CTRL_ADDR, 32'hff, 33'h0);
      apb(0, CTRL_ADDR, 32'h0, 33'h7);
      apb(1, 12'h010, 32'h1, {1'b1, 32'h0});
      stop_test();
   end
endmodule // dtr_receiver_tb
